// file: hw/adc_config_status_regs.sv
/*
  APB register bank for converter configuration and run status: filter and
  settle selection, main start delay, gain trim loaded from OTP, protector
  and converter run flags, sticky event interrupt.
  Assumes OTP data and check-done strobes come from logic on pclk; the
  protector self-test end strobes come from the comparator sequencer.
*/
`timescale 1ns/100ps

module adc_config_status_regs
  import adc_cfg_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // otp and checksum engine
  input  wire logic [7:0]  otp_gain_trim,
  input  wire logic        otp_gain_msb,
  input  wire logic        fact_check_done,
  input  wire logic        cust_check_done,
  // protector sequencer
  input  wire logic        temp_test_end,
  input  wire logic        volt_test_end,
  output logic             temp_comp_on,
  output logic             volt_comp_on,
  // converter datapath
  input  wire logic        main_inputs_in,
  input  wire logic        raw_valid,
  input  wire logic [15:0] raw_data,
  output logic             main_sample,
  output logic             main_conv_en,
  output logic             aux_conv_en,
  output logic             cor_valid,
  output logic [15:0]      cor_data,
  output logic [2:0]       cell_filter_cutoff,
  output logic [2:0]       busbar_filter_cutoff,
  output logic [12:0]      cell_cutoff_dhz,
  output logic [12:0]      busbar_cutoff_dhz,
  output logic [12:0]      aux_cell_settling_sel_us,
  output logic             aux_cell_settling_sel_valid,
  // interrupt
  output logic             irq
);
  logic [7:0]  settle_cfg_q;
  logic [7:0]  delay_cfg_q;
  logic [7:0]  gain_lo_q;
  logic        gain_lo_loaded_q;
  logic [7:0]  conv_ctrl_q;
  logic [1:0]  temp_mode_q;
  logic [1:0]  volt_mode_q;
  logic        fact_done_q;
  logic        cust_done_q;
  logic        temp_run_q;
  logic        volt_run_q;
  logic        temp_off_pend_q;
  logic        volt_off_pend_q;
  logic [7:0]  irq_stat_q;
  logic [7:0]  irq_mask_q;
  main_state_t main_st_q;
  logic        main_inputs_q;

  logic        acc;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic        hit;
  logic [7:0]  rdata_d;
  logic        main_go;
  logic        temp_go;
  logic        volt_go;
  logic        delay_fire;
  logic        stat_rd;
  logic        irq_rd;
  logic [7:0]  ev;

  function automatic logic [12:0] cutoff(input logic [2:0] c);
    unique case (c)
      3'h0: cutoff = CUT0;
      3'h1: cutoff = CUT1;
      3'h2: cutoff = CUT2;
      3'h3: cutoff = CUT3;
      3'h4: cutoff = CUT4;
      3'h6: cutoff = CUT6;
      default: cutoff = CUT5;   // codes 5 and 7
    endcase
  endfunction

  // apb decode; word aligned, upper index bits beyond map are a miss
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign idx = paddr[13:2];
  assign hit = (idx == IDX_FILTER_SETTLE) || (idx == IDX_START_DELAY) ||
               (idx == IDX_GAIN_TRIM_LO) || (idx == IDX_RUN_STATUS) ||
               (idx == IDX_CONV_CTRL) || (idx == IDX_PROT_CTRL) ||
               (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);

  assign main_go = wr && (idx == IDX_CONV_CTRL) && pwdata[CC_MAIN_START];
  assign temp_go = wr && (idx == IDX_PROT_CTRL) && pwdata[PC_TEMP_START];
  assign volt_go = wr && (idx == IDX_PROT_CTRL) && pwdata[PC_VOLT_START];
  assign stat_rd = rd && (idx == IDX_RUN_STATUS);
  assign irq_rd  = rd && (idx == IDX_IRQ_STATUS);

  always_comb
  begin
    rdata_d = RESET_BYTE;
    unique case (idx)
      IDX_FILTER_SETTLE: rdata_d = settle_cfg_q;
      IDX_START_DELAY:   rdata_d = delay_cfg_q;
      IDX_GAIN_TRIM_LO:  rdata_d = gain_lo_q;
      IDX_RUN_STATUS:    rdata_d = {1'b0, fact_done_q, cust_done_q, temp_run_q, volt_run_q,
                                    1'b0, aux_conv_en, main_conv_en};
      IDX_CONV_CTRL:     rdata_d = conv_ctrl_q & CONV_CTRL_MASK;
      IDX_PROT_CTRL:     rdata_d = {1'b0, volt_mode_q, 1'b0, 1'b0, temp_mode_q, 1'b0};
      IDX_IRQ_STATUS:    rdata_d = irq_stat_q;
      IDX_IRQ_MASK:      rdata_d = irq_mask_q;
      default:           rdata_d = RESET_BYTE;
    endcase
  end

  // zero-wait answer: pready is a flop raised in every access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(idx < 12'h800 && hit);
      prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rdata_d} : 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_cfg_q <= RESET_BYTE;
      delay_cfg_q  <= RESET_BYTE;
      conv_ctrl_q  <= RESET_BYTE;
      temp_mode_q  <= 2'b00;
      volt_mode_q  <= 2'b00;
      irq_mask_q   <= RESET_BYTE;
    end
    else if (wr)
    begin
      unique case (idx)
        IDX_FILTER_SETTLE: settle_cfg_q <= pwdata[7:0];
        IDX_START_DELAY:   delay_cfg_q  <= pwdata[7:0];
        IDX_CONV_CTRL:     conv_ctrl_q  <= pwdata[7:0] & CONV_CTRL_MASK;
        IDX_PROT_CTRL:
        begin
          if (pwdata[PC_TEMP_START])
            temp_mode_q <= pwdata[PC_TEMP_MODE +: 2];
          if (pwdata[PC_VOLT_START])
            volt_mode_q <= pwdata[PC_VOLT_MODE +: 2];
        end
        IDX_IRQ_MASK:      irq_mask_q   <= pwdata[7:0] & IRQ_MASK_BITS;
        default:           ;
      endcase
    end
  end

  // gain trim: catch otp byte on first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_lo_q        <= RESET_BYTE;
      gain_lo_loaded_q <= 1'b0;
    end
    else if (!gain_lo_loaded_q)
    begin
      gain_lo_q        <= otp_gain_trim;
      gain_lo_loaded_q <= 1'b1;
    end
    else if (wr && idx == IDX_GAIN_TRIM_LO)
      gain_lo_q <= pwdata[7:0];
  end

  // check-done flags: set wins over read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fact_done_q <= 1'b0;
      cust_done_q <= 1'b0;
    end
    else
    begin
      fact_done_q <= fact_check_done || (fact_done_q && !stat_rd);
      cust_done_q <= cust_check_done || (cust_done_q && !stat_rd);
    end
  end

  // temperature protector: comparators off one cycle before run flag clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_run_q      <= 1'b0;
      temp_comp_on    <= 1'b0;
      temp_off_pend_q <= 1'b0;
    end
    else if (temp_go)
    begin
      temp_run_q      <= (pwdata[PC_TEMP_MODE +: 2] != 2'b00);
      temp_comp_on    <= (pwdata[PC_TEMP_MODE +: 2] != 2'b00);
      temp_off_pend_q <= 1'b0;
    end
    else if (temp_test_end && temp_run_q)
    begin
      temp_comp_on    <= 1'b0;
      temp_off_pend_q <= 1'b1;
    end
    else if (temp_off_pend_q)
    begin
      temp_run_q      <= 1'b0;
      temp_off_pend_q <= 1'b0;
    end
  end

  // voltage protector, same sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      volt_run_q      <= 1'b0;
      volt_comp_on    <= 1'b0;
      volt_off_pend_q <= 1'b0;
    end
    else if (volt_go)
    begin
      volt_run_q      <= (pwdata[PC_VOLT_MODE +: 2] != 2'b00);
      volt_comp_on    <= (pwdata[PC_VOLT_MODE +: 2] != 2'b00);
      volt_off_pend_q <= 1'b0;
    end
    else if (volt_test_end && volt_run_q)
    begin
      volt_comp_on    <= 1'b0;
      volt_off_pend_q <= 1'b1;
    end
    else if (volt_off_pend_q)
    begin
      volt_run_q      <= 1'b0;
      volt_off_pend_q <= 1'b0;
    end
  end

  // main converter start; inputs are captured from pclk logic on the start write
  start_delay_timer u_delay
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (main_go),
    .code    (delay_cfg_q[5:0]),
    .fire    (delay_fire)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_st_q    <= ST_IDLE;
      main_conv_en <= 1'b0;
      main_sample  <= 1'b0;
      main_inputs_q <= 1'b0;
    end
    else
    begin
      main_sample   <= main_go;
      main_inputs_q <= main_go ? main_inputs_in : main_inputs_q;
      unique case (main_st_q)
        ST_IDLE:
          if (main_go)
            main_st_q <= ST_WAIT;
        ST_WAIT:
          if (delay_fire)
          begin
            main_st_q    <= ST_RUN;
            main_conv_en <= 1'b1;
          end
        ST_RUN:
          if (main_go)
          begin
            main_st_q    <= ST_WAIT;
            main_conv_en <= 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aux_conv_en <= 1'b0;
    else
      aux_conv_en <= conv_ctrl_q[CC_AUX_ON];
  end

  // filter and settle selections
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_filter_cutoff   <= 3'h0;
      busbar_filter_cutoff <= 3'h0;
      cell_cutoff_dhz      <= CUT0;
      busbar_cutoff_dhz    <= CUT0;
      aux_cell_settling_sel_us        <= 13'(SETTLE0_US);
      aux_cell_settling_sel_valid     <= 1'b1;
    end
    else
    begin
      cell_filter_cutoff   <= settle_cfg_q[CUT_LSB +: 3];
      busbar_filter_cutoff <= settle_cfg_q[BB_LSB +: 3];
      cell_cutoff_dhz      <= cutoff(settle_cfg_q[CUT_LSB +: 3]);
      busbar_cutoff_dhz    <= cutoff(settle_cfg_q[BB_LSB +: 3]);
      aux_cell_settling_sel_valid     <= (settle_cfg_q[SETTLE_LSB +: 2] != 2'b11);
      unique case (settle_cfg_q[SETTLE_LSB +: 2])
        2'b00: aux_cell_settling_sel_us <= 13'(SETTLE0_US);
        2'b01: aux_cell_settling_sel_us <= 13'(SETTLE1_US);
        2'b10: aux_cell_settling_sel_us <= 13'(SETTLE2_US);
        2'b11: aux_cell_settling_sel_us <= 13'(SETTLE0_US);
      endcase
    end
  end

  gain_corrector u_gain
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .trim      ({otp_gain_msb, gain_lo_q}),
    .in_valid  (raw_valid),
    .in_data   (raw_data),
    .out_valid (cor_valid),
    .out_data  (cor_data)
  );

  // sticky events, cleared by reading; a same-cycle event survives
  assign ev = {3'b000, main_go, volt_off_pend_q, temp_off_pend_q, cust_check_done, fact_check_done};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= RESET_BYTE;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= ev | (irq_rd ? RESET_BYTE : irq_stat_q);
      irq        <= |((ev | (irq_rd ? RESET_BYTE : irq_stat_q)) & irq_mask_q);
    end
  end

  chk_status_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    stat_rd && !fact_check_done |=> !fact_done_q)
    else $error("factory flag survived status read");
  chk_temp_off_order: assert property (@(posedge pclk) disable iff (!presetn)
    temp_test_end && temp_run_q && !temp_go |=> !temp_comp_on && temp_run_q ##1 !temp_run_q)
    else $error("temperature shutdown order wrong");
  chk_volt_off_order: assert property (@(posedge pclk) disable iff (!presetn)
    volt_test_end && volt_run_q && !volt_go |=> !volt_comp_on && volt_run_q ##1 !volt_run_q)
    else $error("voltage shutdown order wrong");
  chk_temp_mode_flag: assert property (@(posedge pclk) disable iff (!presetn)
    temp_go |=> temp_run_q == ($past(pwdata[2:1]) != 2'b00))
    else $error("temperature run flag not mode driven");
  chk_volt_mode_flag: assert property (@(posedge pclk) disable iff (!presetn)
    volt_go |=> volt_run_q == ($past(pwdata[6:5]) != 2'b00))
    else $error("voltage run flag not mode driven");
  chk_start_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && idx == IDX_CONV_CTRL |=> prdata[CC_MAIN_START] == 1'b0)
    else $error("start bit read back as one");
  chk_zero_delay_start: assert property (@(posedge pclk) disable iff (!presetn)
    main_go && (delay_cfg_q[5:0] == 6'h00 || delay_cfg_q[5:0] > 6'd40) |-> ##2 main_conv_en)
    else $error("no-delay start not immediate");
  chk_delay_holds_off: assert property (@(posedge pclk) disable iff (!presetn)
    main_go && delay_cfg_q[5:0] == 6'h01 |=> !main_conv_en [*8])
    else $error("converter enabled before delay");
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && idx == IDX_RUN_STATUS |=> prdata[7] == 1'b0 && prdata[2] == 1'b0)
    else $error("reserved status bit set");
  chk_trim_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    !gain_lo_loaded_q |=> gain_lo_q == $past(otp_gain_trim))
    else $error("otp trim not loaded");
endmodule

// file: hw/adc_cfg_pkg.sv
/*
  Constants for the converter configuration and run-status register bank:
  word offsets, field positions, reset values, timing figures and states.
  Assumes a 20 MHz pclk.
*/
package adc_cfg_pkg;

  // printed offsets are register indices; byte address is index times four
  localparam logic [11:0] IDX_FILTER_SETTLE = 12'h007;
  localparam logic [11:0] IDX_START_DELAY   = 12'h008;
  localparam logic [11:0] IDX_GAIN_TRIM_LO  = 12'h01b;
  localparam logic [11:0] IDX_RUN_STATUS    = 12'h52c;
  localparam logic [11:0] IDX_CONV_CTRL     = 12'h030;
  localparam logic [11:0] IDX_PROT_CTRL     = 12'h031;
  localparam logic [11:0] IDX_IRQ_STATUS    = 12'h032;
  localparam logic [11:0] IDX_IRQ_MASK      = 12'h033;

  // run status fields
  localparam int ST_FACT_DONE = 6;
  localparam int ST_CUST_DONE = 5;
  localparam int ST_TEMP_RUN  = 4;
  localparam int ST_VOLT_RUN  = 3;
  localparam int ST_AUX_RUN   = 1;
  localparam int ST_MAIN_RUN  = 0;
  localparam logic [7:0] RUN_STATUS_MASK = 8'h7b;

  // filter/settle fields
  localparam int CUT_LSB    = 0;
  localparam int BB_LSB     = 3;
  localparam int SETTLE_LSB = 6;

  // conversion control fields
  localparam int CC_MAIN_START = 2;
  localparam int CC_AUX_ON     = 3;
  localparam logic [7:0] CONV_CTRL_MASK = 8'h0b;

  // protector control fields
  localparam int PC_TEMP_START = 0;
  localparam int PC_TEMP_MODE  = 1;
  localparam int PC_VOLT_START = 4;
  localparam int PC_VOLT_MODE  = 5;

  // interrupt events
  localparam int EV_FACT_DONE  = 0;
  localparam int EV_CUST_DONE  = 1;
  localparam int EV_TEMP_END   = 2;
  localparam int EV_VOLT_END   = 3;
  localparam int EV_MAIN_START = 4;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h1f;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // start delay: 5 us steps up to 200 us
  localparam int CLK_MHZ          = 20;
  localparam int DELAY_STEP_US    = 5;
  localparam int DELAY_MAX_US     = 200;
  localparam int STEP_CYCLES      = DELAY_STEP_US * CLK_MHZ;
  localparam logic [5:0] DELAY_MAX_CODE = 6'(DELAY_MAX_US / DELAY_STEP_US);

  // settle times in us, codes 0..2
  localparam int SETTLE0_US = 4300;
  localparam int SETTLE1_US = 2300;
  localparam int SETTLE2_US = 1300;

  // filter cut-off in tenths of Hz
  localparam logic [12:0] CUT0 = 13'd65;
  localparam logic [12:0] CUT1 = 13'd130;
  localparam logic [12:0] CUT2 = 13'd260;
  localparam logic [12:0] CUT3 = 13'd530;
  localparam logic [12:0] CUT4 = 13'd1110;
  localparam logic [12:0] CUT5 = 13'd2400;
  localparam logic [12:0] CUT6 = 13'd6000;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} main_state_t;

endpackage

// file: hw/start_delay_timer.sv
/*
  Main converter start delay: counts whole 5 us steps after a start pulse.
  Assumes start arrives from logic on pclk.
*/
`timescale 1ns/100ps
module start_delay_timer
  import adc_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       start,
  input  wire logic [5:0] code,
  // result
  output logic            fire
);
  logic [6:0] step_q;
  logic [5:0] left_q;
  logic       busy_q;

  // code above the range means no delay
  function automatic logic [5:0] eff_code(input logic [5:0] c);
    eff_code = (c > DELAY_MAX_CODE) ? 6'h00 : c;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q <= 7'h00;
      left_q <= 6'h00;
      busy_q <= 1'b0;
      fire   <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (start)
      begin
        step_q <= 7'h00;
        left_q <= eff_code(code);
        busy_q <= (eff_code(code) != 6'h00);
        fire   <= (eff_code(code) == 6'h00);
      end
      else if (busy_q)
      begin
        if (step_q == 7'(STEP_CYCLES - 1))
        begin
          step_q <= 7'h00;
          left_q <= left_q - 6'h01;
          if (left_q == 6'h01)
          begin
            busy_q <= 1'b0;
            fire   <= 1'b1;
          end
        end
        else
          step_q <= step_q + 7'h01;
      end
    end
  end
endmodule

// file: hw/gain_corrector.sv
/*
  Applies the gain trim to conversion results: out = in + in*trim/2^15,
  trim is a signed 9-bit code, about 0.0031 % per step.
  Assumes results arrive from logic on pclk.
*/
`timescale 1ns/100ps
module gain_corrector
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // trim
  input  wire logic [8:0]  trim,
  // raw sample
  input  wire logic        in_valid,
  input  wire logic [15:0] in_data,
  // corrected sample
  output logic             out_valid,
  output logic [15:0]      out_data
);
  logic signed [25:0] prod;
  assign prod = $signed({1'b0, in_data}) * $signed(trim);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_data <= in_data + 16'(prod >>> 15);
    end
  end
endmodule

// file: tb/adc_config_status_regs_tb_top.sv
/*
  Self-checking bench for the converter configuration and run-status bank.
  Assumes the design package and design files are compiled first; the bench
  plays APB master, OTP, check engine, protector sequencer and converter.
*/
`timescale 1ns/100ps
module adc_config_status_regs_tb_top;
  import adc_cfg_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [7:0]  otp_gain_trim;
  logic        otp_gain_msb;
  logic        fact_check_done;
  logic        cust_check_done;
  logic        temp_test_end;
  logic        volt_test_end;
  logic        temp_comp_on;
  logic        volt_comp_on;
  logic        main_inputs_in;
  logic        raw_valid;
  logic [15:0] raw_data;
  logic        main_sample;
  logic        main_conv_en;
  logic        aux_conv_en;
  logic        cor_valid;
  logic [15:0] cor_data;
  logic [2:0]  cell_filter_cutoff;
  logic [2:0]  busbar_filter_cutoff;
  logic [12:0] cell_cutoff_dhz;
  logic [12:0] busbar_cutoff_dhz;
  logic [12:0] aux_cell_settling_sel_us;
  logic        aux_cell_settling_sel_valid;
  logic        irq;
  int          error_cnt;
  int          checks_done;
  int          sample_cnt;
  logic [31:0] rd;
  logic        er;
  logic [12:0] cut_tab [8];
  logic [12:0] settle_tab [3];

  adc_config_status_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .otp_gain_trim(otp_gain_trim), .otp_gain_msb(otp_gain_msb),
    .fact_check_done(fact_check_done), .cust_check_done(cust_check_done),
    .temp_test_end(temp_test_end), .volt_test_end(volt_test_end), .temp_comp_on(temp_comp_on),
    .volt_comp_on(volt_comp_on), .main_inputs_in(main_inputs_in), .raw_valid(raw_valid),
    .raw_data(raw_data), .main_sample(main_sample), .main_conv_en(main_conv_en),
    .aux_conv_en(aux_conv_en), .cor_valid(cor_valid), .cor_data(cor_data),
    .cell_filter_cutoff(cell_filter_cutoff), .busbar_filter_cutoff(busbar_filter_cutoff),
    .cell_cutoff_dhz(cell_cutoff_dhz), .busbar_cutoff_dhz(busbar_cutoff_dhz),
    .aux_cell_settling_sel_us(aux_cell_settling_sel_us), .aux_cell_settling_sel_valid(aux_cell_settling_sel_valid), .irq(irq));

  always #25 pclk = ~pclk;

  always @(posedge pclk)
    if (main_sample === 1'b1)
      sample_cnt <= sample_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // answer taken at the rising edge that samples pready; release only after it
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    error_cnt++;
    close_out();
  end

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; otp_gain_trim = 8'h5a; otp_gain_msb = 1'b0;
    fact_check_done = 1'b0; cust_check_done = 1'b0; temp_test_end = 1'b0;
    volt_test_end = 1'b0; main_inputs_in = 1'b1; raw_valid = 1'b0; raw_data = '0;
    error_cnt = 0; checks_done = 0; sample_cnt = 0;
    cut_tab = '{CUT0, CUT1, CUT2, CUT3, CUT4, CUT5, CUT6, CUT5};
    settle_tab = '{13'(SETTLE0_US), 13'(SETTLE1_US), 13'(SETTLE2_US)};
    do_reset();
    apb(0, IDX_GAIN_TRIM_LO, 0); check(rd, 32'h5a);
    apb(0, IDX_RUN_STATUS, 0); check(rd, 32'h0);
    apb(1, IDX_RUN_STATUS, 8'hff); apb(0, IDX_RUN_STATUS, 0); check(rd, 32'h0);
    apb(0, 12'hfff, 0); check({er, rd[30:0]}, 32'h80000000);
    $display("test reset_and_access done");
    for (int c = 0; c < 8; c++)
    begin
      apb(1, IDX_FILTER_SETTLE, {2'(c % 4), 3'(7 - c), 3'(c)});
      repeat (2) @(negedge pclk);
      check(cell_cutoff_dhz, cut_tab[c]);
      check(busbar_cutoff_dhz, cut_tab[7 - c]);
      check(aux_cell_settling_sel_valid, (c % 4) != 3);
      if (c % 4 != 3)
        check(aux_cell_settling_sel_us, settle_tab[c % 4]);
      apb(0, IDX_FILTER_SETTLE, 0); check(rd, {24'h0, 2'(c % 4), 3'(7 - c), 3'(c)});
    end
    $display("test filter_settle done");
    for (int t = 0; t < 2; t++)
    begin
      otp_gain_msb <= t[0];
      @(posedge pclk);
      raw_valid <= 1'b1;
      raw_data  <= 16'h4000;
      @(posedge pclk);
      raw_valid <= 1'b0;
      @(negedge pclk);
      // trim +90 adds 45 counts, trim -166 removes 83
      check({cor_valid, cor_data}, t ? {1'b1, 16'h3fad} : {1'b1, 16'h402d});
    end
    $display("test gain_trim done");
    for (int p = 0; p < 2; p++)
    begin
      apb(1, IDX_PROT_CTRL, p ? 8'h30 : 8'h03);
      apb(0, IDX_RUN_STATUS, 0); check(rd[p ? ST_VOLT_RUN : ST_TEMP_RUN], 1);
      check(p ? volt_comp_on : temp_comp_on, 1);
      @(posedge pclk);
      if (p) volt_test_end <= 1'b1; else temp_test_end <= 1'b1;
      @(posedge pclk);
      volt_test_end <= 1'b0;
      temp_test_end <= 1'b0;
      @(negedge pclk);
      check(p ? volt_comp_on : temp_comp_on, 0);
      apb(0, IDX_RUN_STATUS, 0); check(rd[p ? ST_VOLT_RUN : ST_TEMP_RUN], 0);
      apb(1, IDX_PROT_CTRL, p ? 8'h10 : 8'h01);
      apb(0, IDX_RUN_STATUS, 0); check(rd[p ? ST_VOLT_RUN : ST_TEMP_RUN], 0);
    end
    $display("test protectors done");
    apb(1, IDX_CONV_CTRL, 8'h08);
    repeat (2) @(negedge pclk);
    check(aux_conv_en, 1);
    apb(0, IDX_RUN_STATUS, 0); check(rd[ST_AUX_RUN], 1);
    $display("test aux_run done");
    @(posedge pclk);
    fact_check_done <= 1'b1;
    @(posedge pclk);
    fact_check_done <= 1'b0;
    apb(0, IDX_RUN_STATUS, 0); check(rd[ST_FACT_DONE], 1);
    apb(0, IDX_RUN_STATUS, 0); check(rd[ST_FACT_DONE], 0);
    // mask bit set means the event may raise irq; irq follows the mask one cycle late
    apb(1, IDX_IRQ_MASK, 8'h00);
    repeat (2) @(negedge pclk);
    check(irq, 0);
    apb(1, IDX_IRQ_MASK, IRQ_MASK_BITS);
    repeat (2) @(negedge pclk);
    check(irq, 1);
    apb(0, IDX_IRQ_STATUS, 0); check(rd[EV_FACT_DONE], 1);
    @(negedge pclk);
    check(irq, 0);
    $display("test check_done_irq done");
    // out-of-range delay code starts at once, then a fresh reset for a real delay
    for (int d = 0; d < 2; d++)
    begin
      int n;
      if (d) do_reset();
      apb(1, IDX_START_DELAY, d ? 8'h01 : 8'h3f);
      sample_cnt = 0;
      apb(1, IDX_CONV_CTRL, 8'h04);
      n = 0;
      while (main_conv_en !== 1'b1 && n < 300)
      begin
        @(negedge pclk);
        n++;
      end
      @(negedge pclk);
      check(d ? (n >= STEP_CYCLES && n <= STEP_CYCLES + 4) : (n <= 4), 1);
      check(sample_cnt, 1);
      apb(0, IDX_CONV_CTRL, 0); check(rd[CC_MAIN_START], 0);
      apb(0, IDX_RUN_STATUS, 0); check(rd[ST_MAIN_RUN], 1);
    end
    $display("test main_start done");
    close_out();
  end
endmodule
